// *** pin_select_defs.vh ***
// Register map, field layout and reset values of the remappable pin select block
`ifndef PIN_SELECT_DEFS_VH
`define PIN_SELECT_DEFS_VH

// ==========================================================
// Register byte addresses
`define CAP_SEL_OFFSET 8'h00
`define MAP_8_9_OFFSET 8'h04
`define MAP_10_11_OFFSET 8'h08
`define MAP_20_21_OFFSET 8'h0C
`define MAP_22_23_OFFSET 8'h10

// ==========================================================
// Field layout
`define SEL_WIDTH 6
`define HI_FIELD_LSB 8
`define LO_FIELD_LSB 0
`define SRC_COUNT 64
`define OUT_PIN_COUNT 8
`define MAP_REG_COUNT 4

// ==========================================================
// Reset values
`define CAP_SEL_RESET 6'h3F
`define MAP_RESET 6'h00
`define NO_FUNCTION 6'h00

`endif

// *** sel_mux.v ***
// One registered six-bit selector: picks a source line and flags a nonzero selection
`timescale 1ns/1ps
`default_nettype none
`include "pin_select_defs.vh"

module sel_mux (
  input wire clock,
  input wire rst,
  input wire [`SEL_WIDTH-1:0] sel,
  input wire [`SRC_COUNT-1:0] src,
  output reg out_r,
  output reg active_r
);

  // ==========================================================
  // Registered pick, so every top output comes from a flop
  always @(posedge clock) begin
    if (rst) begin
      out_r <= 1'b0;
      active_r <= 1'b0;
    end else begin
      out_r <= src[sel];
      active_r <= (sel != `NO_FUNCTION);
    end
  end

endmodule
`default_nettype wire

// *** remappable_pin_select.v ***
// Remappable pin select: capture input routing and output pin mapping over Wishbone
//
// How it works
// - Bits 13:8 of capture select register choose pin feeding capture channel two.
// - Bits 5:0 of capture select register choose pin feeding capture channel one.
// - Each output pin with a nonzero field is driven by the peripheral function numbered in its field.
// - Output map registers: higher pin in bits 13:8, lower pin in bits 5:0.
// - Bits 15:14 and 7:6 of every register read zero, writes ignored.
// - Reset sets capture selector bits to one, output map bits to zero.
// - All selector and map bits are read/write; reads return last written value.
//
// Chosen here: register access over Wishbone and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "pin_select_defs.vh"

module remappable_pin_select (
  input wire clock,
  input wire rst,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [31:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  output reg [31:0] wb_dat_o,
  output reg wb_ack_o,
  input wire [`SRC_COUNT-1:0] remappable_io_pin,
  input wire [`SRC_COUNT-1:0] periph_func_out,
  output wire capture_channel_one,
  output wire capture_channel_two,
  output wire [`OUT_PIN_COUNT-1:0] remap_pin_out,
  output wire [`OUT_PIN_COUNT-1:0] remap_pin_oe
);

  // ==========================================================
  // Register state
  reg [`SEL_WIDTH-1:0] capture2_pin_selector_r;
  reg [`SEL_WIDTH-1:0] capture1_pin_selector_r;
  // Capture selectors reset to the top pin number
  // Output fields packed low pin first: 8,9,10,11,20,21,22,23
  reg [`OUT_PIN_COUNT*`SEL_WIDTH-1:0] out_map_r;

  wire req;
  wire [7:0] offset;
  reg hit;
  reg [1:0] map_idx;
  reg is_cap;
  reg [31:0] rd_nxt;
  wire [`SRC_COUNT-1:0] func_src;
  wire adr_ok;
  wire take;
  wire wr_take;
  wire wr_hi;
  wire wr_lo;

  assign req = wb_cyc_i & wb_stb_i;
  assign offset = wb_adr_i[7:0];
  // Upper address bits must be zero, so no alias reaches a register
  assign adr_ok = (wb_adr_i[31:8] == 24'h000000);

  // ==========================================================
  // Address decode
  always @* begin
    hit = 1'b0;
    is_cap = 1'b0;
    map_idx = 2'h0;
    if (adr_ok) begin
      // Unlisted offsets are acked and read zero
      case (offset)
        `CAP_SEL_OFFSET: begin
          hit = 1'b1;
          is_cap = 1'b1;
        end
        `MAP_8_9_OFFSET: begin
          hit = 1'b1;
          map_idx = 2'h0;
        end
        `MAP_10_11_OFFSET: begin
          hit = 1'b1;
          map_idx = 2'h1;
        end
        `MAP_20_21_OFFSET: begin
          hit = 1'b1;
          map_idx = 2'h2;
        end
        `MAP_22_23_OFFSET: begin
          hit = 1'b1;
          map_idx = 2'h3;
        end
        default: begin
          hit = 1'b0;
        end
      endcase
    end
  end

  // ==========================================================
  // Read data; unimplemented and unmapped bits read as zero
  // Picked before the flop, so read data leaves a register
  always @* begin
    rd_nxt = 32'h00000000;
    if (hit) begin
      if (is_cap) begin
        rd_nxt[`HI_FIELD_LSB +: `SEL_WIDTH] = capture2_pin_selector_r;
        rd_nxt[`LO_FIELD_LSB +: `SEL_WIDTH] = capture1_pin_selector_r;
      end else begin
        rd_nxt[`HI_FIELD_LSB +: `SEL_WIDTH] =
          out_map_r[(2*map_idx+1)*`SEL_WIDTH +: `SEL_WIDTH];
        rd_nxt[`LO_FIELD_LSB +: `SEL_WIDTH] =
          out_map_r[(2*map_idx)*`SEL_WIDTH +: `SEL_WIDTH];
      end
    end
  end

  // ==========================================================
  // Bus handshake: ack one cycle after request, dropped the cycle after
  // A request held past its ack is taken again; the master must drop it
  assign take = req & ~wb_ack_o;
  always @(posedge clock) begin
    if (rst) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= take;
    end
  end

  // ==========================================================
  // Read data register, zero outside the ack cycle
  always @(posedge clock) begin
    if (rst) begin
      wb_dat_o <= 32'h00000000;
    end else if (take) begin
      wb_dat_o <= rd_nxt;
    end else begin
      wb_dat_o <= 32'h00000000;
    end
  end

  // ==========================================================
  // Write strobes, taken at the edge where the master sees ack
  // Only lanes 0 and 1 carry implemented bits; upper lanes ignored
  assign wr_take = req & wb_ack_o & wb_we_i & hit;
  assign wr_hi = wr_take & wb_sel_i[1];
  assign wr_lo = wr_take & wb_sel_i[0];

  // ==========================================================
  // Capture selector register
  always @(posedge clock) begin
    if (rst) begin
      capture2_pin_selector_r <= `CAP_SEL_RESET;
      capture1_pin_selector_r <= `CAP_SEL_RESET;
    end else begin
      if (wr_hi & is_cap) begin
        capture2_pin_selector_r <= wb_dat_i[`HI_FIELD_LSB +: `SEL_WIDTH];
      end
      if (wr_lo & is_cap) begin
        capture1_pin_selector_r <= wb_dat_i[`LO_FIELD_LSB +: `SEL_WIDTH];
      end
    end
  end

  // ==========================================================
  // Output map registers
  // Bits 15:14 and 7:6 have no storage, so writes there vanish
  always @(posedge clock) begin
    if (rst) begin
      out_map_r <= {`OUT_PIN_COUNT{`MAP_RESET}};
    end else begin
      if (wr_hi & ~is_cap) begin
        out_map_r[(2*map_idx+1)*`SEL_WIDTH +: `SEL_WIDTH] <=
          wb_dat_i[`HI_FIELD_LSB +: `SEL_WIDTH];
      end
      if (wr_lo & ~is_cap) begin
        out_map_r[(2*map_idx)*`SEL_WIDTH +: `SEL_WIDTH] <=
          wb_dat_i[`LO_FIELD_LSB +: `SEL_WIDTH];
      end
    end
  end

  // ==========================================================
  // Capture input routing
  // One flop of latency; capture edges shift by one clock
  // Selector zero means pin zero; capture has no off state
  sel_mux cap1_mux (
    .clock(clock),
    .rst(rst),
    .sel(capture1_pin_selector_r),
    .src(remappable_io_pin),
    .out_r(capture_channel_one),
    .active_r()
  );

  sel_mux cap2_mux (
    .clock(clock),
    .rst(rst),
    .sel(capture2_pin_selector_r),
    .src(remappable_io_pin),
    .out_r(capture_channel_two),
    .active_r()
  );

  // ==========================================================
  // Output pin routing
  // Function number zero is forced low and releases the pin
  assign func_src = {periph_func_out[`SRC_COUNT-1:1], 1'b0};

  // Data and enable share one flop stage, so they never skew
  genvar g;
  generate
    for (g = 0; g < `OUT_PIN_COUNT; g = g + 1) begin : out_pin
      sel_mux pin_mux (
        .clock(clock),
        .rst(rst),
        .sel(out_map_r[g*`SEL_WIDTH +: `SEL_WIDTH]),
        .src(func_src),
        .out_r(remap_pin_out[g]),
        .active_r(remap_pin_oe[g])
      );
    end
  endgenerate

endmodule
`default_nettype wire

// *** pin_select_checker.sv ***
// Checker of the pin select bus and routing ports
`timescale 1ns/1ps
`default_nettype none
module pin_select_checker (
  input wire clock, input wire rst, input wire wb_cyc_i, input wire wb_stb_i,
  input wire wb_we_i, input wire [31:0] wb_adr_i, input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i, input wire [31:0] wb_dat_o, input wire wb_ack_o,
  input wire [63:0] remappable_io_pin, input wire [63:0] periph_func_out,
  input wire capture_channel_one, input wire capture_channel_two,
  input wire [7:0] remap_pin_out, input wire [7:0] remap_pin_oe
);
  // Set by any write, so reset-value checks stop before a selector can move
  logic wr_r;
  always @(posedge clock) wr_r <= rst ? 1'h0 : wr_r | (wb_ack_o & wb_we_i);
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  ack_next_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("ack late");
  ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held");
  rsvd_zero_a: assert property (wb_ack_o |-> (wb_dat_o & 32'hFFFFC0C0) == 32'h0)
    else $error("reserved bits set");
  idle_data_a: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
    else $error("data outside ack");
  oe_gate_a: assert property ((remap_pin_out & ~remap_pin_oe) == 8'h0)
    else $error("undriven pin high");
  map_reset_a: assert property (!wr_r |-> remap_pin_oe == 8'h0)
    else $error("map not zero");
  cap1_reset_a: assert property (!wr_r && !(wb_ack_o && wb_we_i)
    |=> capture_channel_one == $past(remappable_io_pin[63])) else $error("cap1 route");
  cap2_reset_a: assert property (!wr_r && !(wb_ack_o && wb_we_i)
    |=> capture_channel_two == $past(remappable_io_pin[63])) else $error("cap2 route");
endmodule
bind remappable_pin_select pin_select_checker chk (.*);
`default_nettype wire

// *** pin_far_side.sv ***
// Peripheral outputs and pin levels on the far side
`timescale 1ns/1ps
`default_nettype none
module pin_far_side (
  input wire clock,
  output logic [63:0] pins,
  output logic [63:0] funcs
);
  initial {pins, funcs} = 128'h0;
  // Fresh levels every edge, so a stale route cannot pass
  always @(posedge clock) begin
    pins <= {$urandom, $urandom};
    funcs <= {$urandom, $urandom};
  end
endmodule
`default_nettype wire

// *** remappable_pin_select_test.sv ***
// Self-checking bench of the remappable pin select
`timescale 1ns/1ps
`default_nettype none
module remappable_pin_select_test;
  logic clock = 0, rst = 1, wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0;
  logic [31:0] wb_adr_i = 0, wb_dat_i = 0;
  logic [3:0] wb_sel_i = 0;
  wire [31:0] wb_dat_o;
  wire wb_ack_o, capture_channel_one, capture_channel_two;
  wire [7:0] remap_pin_out, remap_pin_oe;
  wire [63:0] remappable_io_pin, periph_func_out;
  logic [5:0] f [10];
  logic [17:0] e;
  int errors = 0, n_compared = 0, t = 0;
  remappable_pin_select dut (.*);
  pin_far_side far (.clock(clock), .pins(remappable_io_pin), .funcs(periph_func_out));
  initial forever #25 clock = ~clock;
  task results;
    if (errors == 0 && n_compared > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      errors++;
      $display("ERROR %0t got %h want %h", $time, got, exp);
    end
  endtask
  // ==========
  // Reference model, one edge behind like the routing flops
  always @(posedge clock) begin
    t <= t + 1;
    if (t == 20000) begin
      errors++;
      results;
    end
  end
  always @(posedge clock) begin
    for (int k = 0; k < 8; k++) begin
      e[k] <= !rst && f[k+2] != 0 && periph_func_out[f[k+2]];
      e[k+8] <= !rst && f[k+2] != 0;
    end
    e[16] <= !rst && remappable_io_pin[f[0]];
    e[17] <= !rst && remappable_io_pin[f[1]];
  end
  always @(negedge clock) if (t > 0) chk({14'h0, capture_channel_two, capture_channel_one,
    remap_pin_oe, remap_pin_out}, {14'h0, e});
  task do_rst(input int n);
    rst <= 1;
    for (int i = 0; i < 10; i++) f[i] <= i < 2 ? 6'h3F : 6'h00;
    repeat (n) @(posedge clock);
    rst <= 0;
  endtask
  task wb(input logic w, input logic [31:0] a, input logic [3:0] s, input logic [31:0] d);
    int r;
    logic hit;
    r = a[4:2];
    hit = a[31:8] == 0 && a[1:0] == 0 && a[7:2] < 5;
    wb_cyc_i <= 1;
    wb_stb_i <= 1;
    wb_we_i <= w;
    wb_adr_i <= a;
    wb_sel_i <= s;
    wb_dat_i <= d;
    @(posedge clock);
    while (wb_ack_o !== 1'h1) @(posedge clock);
    if (!w) chk(wb_dat_o, hit ? {18'h0, f[2*r+1], 2'h0, f[2*r]} : 32'h0);
    if (w && hit && s[0]) f[2*r] <= d[5:0];
    if (w && hit && s[1]) f[2*r+1] <= d[13:8];
    wb_cyc_i <= 0;
    wb_stb_i <= 0;
    @(posedge clock);
  endtask
  // ==========
  // Main sequence
  initial begin
    void'($urandom(42326));
    do_rst(10);
    for (int r = 0; r < 6; r++) wb(0, r * 4, 0, 0);
    for (int r = 0; r < 5; r++) wb(1, r * 4, 4'hF, 32'hFFFFFFFF);
    for (int r = 0; r < 6; r++) wb(0, r * 4, 0, 0);
    for (int i = 0; i < 400; i++) wb(1'($urandom), ($urandom % 6) * 4
      | ($urandom % 8 == 0) << 8, 4'($urandom), $urandom);
    do_rst(2);
    for (int r = 0; r < 6; r++) wb(0, r * 4, 0, 0);
    results;
  end
endmodule
`default_nettype wire
